// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import wdc_pkg::*;
    logic        sys_clk, sys_rst, reg_write, reg_read, watchdog_reset, watchdog_irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, c, e;
    logic [1:0]  src;
    logic [2:0]  ext;
    int          err_total, n_checks, pulses, width, k, j;
    wdc_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sysctl_clock_source_reg(src),
        .watchdog_source_clock(ext), .watchdog_reset(watchdog_reset), .watchdog_irq(watchdog_irq));
    wdc_sys_model u_sys (.sys_clk(sys_clk), .sys_rst(sys_rst), .watchdog_reset(watchdog_reset),
        .watchdog_source_clock(ext), .rst_pulses(pulses), .rst_width(width));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task summarize;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    initial begin
        #400_000;
        err_total++;
        summarize();
    end
    // ----
    // Tests
    // ----
    initial begin
        {sys_rst, reg_write, reg_read, reg_addr, reg_wdata, src} = {3'b100, 4'h0, 32'h0000_0000, 2'b00};
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wr(4'h1, 32'h0000_007F);
        rd(WDC_ADDR_CONTROL, v); check(v, 32'h0000_0000);
        rd(WDC_ADDR_RELOAD, v); check(v, 32'hFFFF_FFFF);
        rd(WDC_ADDR_STATUS, v); check(v, 32'h0000_0000);
        rd(4'h2, v); check(v, 32'h0000_0000);
        rd(WDC_ADDR_COUNT, v); repeat (20) @(posedge sys_clk); rd(WDC_ADDR_COUNT, c); check(c, v);
        $display("test reset_values done");
        wr(WDC_ADDR_RELOAD, 32'h0010_0000);
        for (k = 0; k < 8; k++) begin
            wr(WDC_ADDR_CONTROL, 32'h0000_0010 | k);
            repeat (300) @(posedge sys_clk);
            rd(WDC_ADDR_COUNT, v);
            repeat (4 * (k == 0 ? 1 : (2 << k)) - 2) @(posedge sys_clk);
            rd(WDC_ADDR_COUNT, c);
            check(v - c, 32'h0000_0004);
        end
        $display("test prescale done");
        wr(WDC_ADDR_CONTROL, 32'h0000_0010);
        wr(WDC_ADDR_RELOAD, 32'h0000_1000);
        repeat (10) @(posedge sys_clk);
        rd(WDC_ADDR_COUNT, v); check(32'(v <= 32'h1000 && v >= 32'h0FF0), 32'h1);
        $display("test kick done");
        wr(WDC_ADDR_CONTROL, 32'h0000_0030);
        wr(WDC_ADDR_RELOAD, 32'h0000_0028);
        for (k = 0; k < 100 && watchdog_irq !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check(32'(k >= 38 && k <= 52), 32'h1);
        rd(WDC_ADDR_STATUS, v); check(v & 32'h1, 32'h1);
        rd(WDC_ADDR_COUNT, c); check(32'(c <= 40 && c >= 30), 32'h1);
        wr(WDC_ADDR_STATUS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        #1 check(32'(watchdog_irq), 32'h0);
        wr(WDC_ADDR_CONTROL, 32'h0000_0000);
        $display("test interrupt done");
        wr(WDC_ADDR_RELOAD, 32'h0000_001E);
        wr(WDC_ADDR_CONTROL, 32'h0000_0050);
        for (k = 0; k < 100 && watchdog_reset !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check(32'(k >= 28 && k <= 45), 32'h1);
        repeat (8) @(posedge sys_clk);
        #1 check(32'(pulses), 32'h1);
        check(32'(width), 32'h4);
        check(32'(watchdog_irq), 32'h0);
        rd(WDC_ADDR_COUNT, c); check(32'(c == 0 || c > 30), 32'h1);
        rd(WDC_ADDR_STATUS, v); check(v, 32'h0000_0002);
        $display("test reset_mode done");
        for (j = 0; j < 3; j++) begin
            @(posedge sys_clk);
            src <= 2'(j);
            wr(WDC_ADDR_CONTROL, 32'h0000_0018);
            repeat (50) @(posedge sys_clk);
            rd(WDC_ADDR_COUNT, v);
            repeat (838) @(posedge sys_clk);
            rd(WDC_ADDR_COUNT, c);
            e = 32'(840 / (6 + 4 * j));
            check(32'((v - c) + 1 >= e && (v - c) <= e + 1), 32'h1);
        end
        $display("test external_clock done");
        summarize();
    end
endmodule : testbench
bind wdc_top wdc_top_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .watchdog_reset(watchdog_reset), .watchdog_irq(watchdog_irq));

// ---- wdc_pkg.sv ----
package wdc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] WDC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] WDC_ADDR_RELOAD  = 4'h4;
    localparam logic [3:0] WDC_ADDR_COUNT   = 4'h8;
    localparam logic [3:0] WDC_ADDR_STATUS  = 4'hC;
    localparam int unsigned WDC_ADDR_W      = 4;
    localparam int unsigned WDC_DATA_W      = 32;
    // Control and status field positions
    localparam int unsigned WDC_CTL_PRESCALE_LSB = 0;
    localparam int unsigned WDC_CTL_EXT_SEL_BIT  = 3;
    localparam int unsigned WDC_CTL_ENABLE_BIT   = 4;
    localparam int unsigned WDC_CTL_IRQ_EN_BIT   = 5;
    localparam int unsigned WDC_CTL_RST_EN_BIT   = 6;
    localparam int unsigned WDC_STS_IRQ_BIT      = 0;
    localparam int unsigned WDC_STS_RST_BIT      = 1;
    // Reset values
    localparam logic [6:0]  WDC_CONTROL_RST = 7'h00;
    localparam logic [31:0] WDC_RELOAD_RST  = 32'hFFFF_FFFF;
    // Timing: load transfer bound and reset pulse width
    localparam int unsigned WDC_LOAD_MAX_CYCLES = 5;
    localparam int unsigned WDC_RST_PULSE_CYC   = 4;

    typedef enum logic [0:0] {WDC_SRC_BUS, WDC_SRC_EXT} wdc_src_t;

    function automatic logic [7:0] wdc_div_mask(input logic [2:0] code);
        case (code)
            3'd0:    wdc_div_mask = 8'h00;
            3'd1:    wdc_div_mask = 8'h03;
            3'd2:    wdc_div_mask = 8'h07;
            3'd3:    wdc_div_mask = 8'h0F;
            3'd4:    wdc_div_mask = 8'h1F;
            3'd5:    wdc_div_mask = 8'h3F;
            3'd6:    wdc_div_mask = 8'h7F;
            default: wdc_div_mask = 8'hFF;
        endcase
    endfunction : wdc_div_mask
endpackage : wdc_pkg

// ---- wdc_sys_model.sv ----
`timescale 1ns/100ps
module wdc_sys_model (
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    input  wire logic  watchdog_reset,
    output logic [2:0] watchdog_source_clock,
    output int         rst_pulses,
    output int         rst_width
);
    logic rst_prev_q;
    // ----
    // Free running external sources, periods 6, 10 and 14 bus clocks
    // ----
    initial begin
        watchdog_source_clock = 3'b000;
        #3;
        fork
            forever #24 watchdog_source_clock[0] = ~watchdog_source_clock[0];
            forever #40 watchdog_source_clock[1] = ~watchdog_source_clock[1];
            forever #56 watchdog_source_clock[2] = ~watchdog_source_clock[2];
        join
    end
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_prev_q <= 1'b0;
            rst_pulses <= 0;
            rst_width  <= 0;
        end else begin
            rst_prev_q <= watchdog_reset;
            if (watchdog_reset && !rst_prev_q) begin
                rst_pulses <= rst_pulses + 1;
                rst_width  <= 1;
            end else if (watchdog_reset) begin
                rst_width <= rst_width + 1;
            end
        end
    end
endmodule : wdc_sys_model

// ---- wdc_tick_gen.sv ----
`timescale 1ns/100ps
module wdc_tick_gen
    import wdc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] ext_clk_in,
    wdc_tick_if.gen         tk
);
    // ----------------------------------------
    // Source synchronisers and edge detect
    // ----------------------------------------
    logic [2:0] s1_q, s2_q, s3_q;
    logic [2:0] s1_d, s2_d, s3_d;
    logic [7:0] div_q, div_d;
    logic       tick_q, tick_d;
    logic       src_tick;
    wdc_src_t   src;

    always_comb begin
        s1_d = ext_clk_in;
        s2_d = s1_q;
        s3_d = s2_q;
        src  = tk.ext_sel ? WDC_SRC_EXT : WDC_SRC_BUS;
        case (src)
            WDC_SRC_EXT: src_tick = (tk.ext_src < 2'd3) && s2_q[tk.ext_src] && !s3_q[tk.ext_src];
            default:     src_tick = 1'b1;
        endcase
        div_d  = div_q;
        tick_d = 1'b0;
        if (!tk.run) begin
            div_d = 8'h00;
        end else if (src_tick) begin
            if ((div_q & wdc_div_mask(tk.prescale_code)) == wdc_div_mask(tk.prescale_code)) begin
                div_d  = 8'h00;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 8'd1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q   <= 3'b000;
            s2_q   <= 3'b000;
            s3_q   <= 3'b000;
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule : wdc_tick_gen

// ---- wdc_tick_if.sv ----
`timescale 1ns/100ps
interface wdc_tick_if;
    logic       ext_sel;
    logic [1:0] ext_src;
    logic [2:0] prescale_code;
    logic       run;
    logic       tick;
    modport gen  (input ext_sel, input ext_src, input prescale_code, input run, output tick);
    modport core (output ext_sel, output ext_src, output prescale_code, output run, input tick);
endinterface : wdc_tick_if

// ---- wdc_top.sv ----
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
// Behaviour
// - Counting starts only after software writes the enable bit, control bit 4, to one.
// - When enabled the counter is loaded from the reload value and counts down from it.
// - With control bit 6 set, reaching zero asserts the watchdog reset output.
// - Writing the reload register before zero reloads the counter and so prevents a timeout.
// - Only in interrupt mode does the counter reload itself after an underflow.
// - The reload value reaches the running counter within five counter clocks.
// - The interrupt output and visible count lag the counter by one bus clock.
// - The counter is 32 bits wide and drops by one per prescaled counter clock.
// - The counter clock source is the bus clock or one of three external clocks.
// - Control bit 3 set selects the external clock, chosen by a separate source register.
// - A 3-bit prescale field divides the source by 1 to 256.
// - The interrupt flag sets within reload times prescaled period plus small fixed slack.
module wdc_top
    import wdc_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic [wdc_pkg::WDC_ADDR_W-1:0] reg_addr,
    input  wire logic [wdc_pkg::WDC_DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [wdc_pkg::WDC_DATA_W-1:0] reg_rdata,
    input  wire logic [1:0]                  sysctl_clock_source_reg,
    input  wire logic [2:0]                  watchdog_source_clock,
    output logic                             watchdog_reset,
    output logic                             watchdog_irq
);
    // ----------------------------------------
    // Prescaled tick
    // ----------------------------------------
    wdc_tick_if tk ();

    wdc_tick_gen u_tick (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .ext_clk_in (watchdog_source_clock),
        .tk         (tk)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [6:0]  ctl_q, ctl_d;
    logic [31:0] reload_q, reload_d;
    logic [31:0] cnt_q, cnt_d;
    logic        load_q, load_d;
    logic        irq_flag_q, irq_flag_d;
    logic        rst_flag_q, rst_flag_d;
    logic [2:0]  rst_cnt_q, rst_cnt_d;
    logic        rst_out_q, rst_out_d;
    logic        irq_out_q, irq_out_d;
    logic [31:0] cnt_vis_q, cnt_vis_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  src_sel_q, src_sel_d;

    logic enable, irq_mode, rst_mode, underflow, wr_ctl, wr_reload, wr_sts;

    assign enable   = ctl_q[WDC_CTL_ENABLE_BIT];
    assign irq_mode = ctl_q[WDC_CTL_IRQ_EN_BIT];
    assign rst_mode = ctl_q[WDC_CTL_RST_EN_BIT];

    assign tk.ext_sel       = ctl_q[WDC_CTL_EXT_SEL_BIT];
    assign tk.ext_src       = src_sel_q;
    assign tk.prescale_code = ctl_q[WDC_CTL_PRESCALE_LSB+:3];
    assign tk.run           = enable;

    assign wr_ctl    = reg_write && (reg_addr == WDC_ADDR_CONTROL);
    assign wr_reload = reg_write && (reg_addr == WDC_ADDR_RELOAD);
    assign wr_sts    = reg_write && (reg_addr == WDC_ADDR_STATUS);
    assign underflow = enable && !load_q && tk.tick && (cnt_q == 32'h0000_0001);

    // ----------------------------------------
    // Counter and control
    // ----------------------------------------
    always_comb begin
        ctl_d      = ctl_q;
        reload_d   = reload_q;
        cnt_d      = cnt_q;
        load_d     = load_q;
        irq_flag_d = irq_flag_q;
        rst_flag_d = rst_flag_q;
        rst_cnt_d  = rst_cnt_q;
        src_sel_d  = sysctl_clock_source_reg;
        if (wr_ctl) begin
            ctl_d = reg_wdata[6:0];
            if (reg_wdata[WDC_CTL_ENABLE_BIT] && !enable) begin
                load_d = 1'b1;
            end
        end
        if (wr_reload) begin
            reload_d = reg_wdata;
            load_d   = 1'b1;
        end
        if (!enable) begin
            cnt_d = cnt_q;
        end else if (load_q) begin
            cnt_d  = reload_q;
            load_d = wr_reload;
        end else if (tk.tick) begin
            cnt_d = cnt_q - 32'h0000_0001;
            if (underflow && irq_mode) begin
                load_d = 1'b1;
            end
        end
        if (wr_sts && reg_wdata[WDC_STS_IRQ_BIT]) begin
            irq_flag_d = 1'b0;
        end
        if (wr_sts && reg_wdata[WDC_STS_RST_BIT]) begin
            rst_flag_d = 1'b0;
        end
        if (underflow && irq_mode) begin
            irq_flag_d = 1'b1;
        end
        if (rst_cnt_q != 3'd0) begin
            rst_cnt_d = rst_cnt_q - 3'd1;
        end
        if (underflow && rst_mode) begin
            rst_flag_d = 1'b1;
            rst_cnt_d  = 3'(WDC_RST_PULSE_CYC);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q      <= WDC_CONTROL_RST;
            reload_q   <= WDC_RELOAD_RST;
            cnt_q      <= WDC_RELOAD_RST;
            load_q     <= 1'b0;
            irq_flag_q <= 1'b0;
            rst_flag_q <= 1'b0;
            rst_cnt_q  <= 3'd0;
            src_sel_q  <= 2'd0;
        end else begin
            ctl_q      <= ctl_d;
            reload_q   <= reload_d;
            cnt_q      <= cnt_d;
            load_q     <= load_d;
            irq_flag_q <= irq_flag_d;
            rst_flag_q <= rst_flag_d;
            rst_cnt_q  <= rst_cnt_d;
            src_sel_q  <= src_sel_d;
        end
    end

    // ----------------------------------------
    // Outputs and read port
    // ----------------------------------------
    always_comb begin
        rst_out_d = (rst_cnt_q != 3'd0);
        irq_out_d = irq_flag_q;
        cnt_vis_d = cnt_q;
        rdata_d   = 32'h0000_0000;
        if (reg_read) begin
            case (reg_addr)
                WDC_ADDR_CONTROL: rdata_d = {25'h0, ctl_q};
                WDC_ADDR_RELOAD:  rdata_d = reload_q;
                WDC_ADDR_COUNT:   rdata_d = cnt_vis_q;
                WDC_ADDR_STATUS:  rdata_d = {30'h0, rst_flag_q, irq_flag_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_out_q <= 1'b0;
            irq_out_q <= 1'b0;
            cnt_vis_q <= WDC_RELOAD_RST;
            rdata_q   <= 32'h0000_0000;
        end else begin
            rst_out_q <= rst_out_d;
            irq_out_q <= irq_out_d;
            cnt_vis_q <= cnt_vis_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata      = rdata_q;
    assign watchdog_reset = rst_out_q;
    assign watchdog_irq   = irq_out_q;
endmodule : wdc_top

// ---- wdc_top_props.sv ----
`timescale 1ns/100ps
module wdc_top_props
    import wdc_pkg::*;
(
    input wire logic                            sys_clk,
    input wire logic                            sys_rst,
    input wire logic [wdc_pkg::WDC_ADDR_W-1:0]  reg_addr,
    input wire logic [wdc_pkg::WDC_DATA_W-1:0]  reg_wdata,
    input wire logic                            reg_write,
    input wire logic                            reg_read,
    input wire logic [wdc_pkg::WDC_DATA_W-1:0]  reg_rdata,
    input wire logic                            watchdog_reset,
    input wire logic                            watchdog_irq
);
    logic [6:0]  ctl_q;
    logic [31:0] rl_q;
    wire         clr = reg_write && reg_addr == WDC_ADDR_STATUS && reg_wdata[WDC_STS_IRQ_BIT];
    wire         unm = reg_addr[1:0] != 2'b00;
    // ----
    // Shadow of software writes
    // ----
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q <= WDC_CONTROL_RST;
            rl_q  <= WDC_RELOAD_RST;
        end else if (reg_write && reg_addr == WDC_ADDR_CONTROL) begin
            ctl_q <= reg_wdata[6:0];
        end else if (reg_write && reg_addr == WDC_ADDR_RELOAD) begin
            rl_q <= reg_wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside read");
    a_unmapped_zero: assert property ($past(reg_read && unm) |-> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_ctl_read: assert property ($past(reg_read && reg_addr == WDC_ADDR_CONTROL) |-> reg_rdata == {25'h0, $past(ctl_q)})
        else $error("control readback wrong");
    a_reload_read: assert property ($past(reg_read && reg_addr == WDC_ADDR_RELOAD) |-> reg_rdata == $past(rl_q))
        else $error("reload readback wrong");
    a_rst_width: assert property ($rose(watchdog_reset) |-> watchdog_reset [*4] ##1 !watchdog_reset)
        else $error("reset pulse width wrong");
    a_rst_mode: assert property ($rose(watchdog_reset) |-> ctl_q[WDC_CTL_RST_EN_BIT])
        else $error("reset without reset mode");
    a_irq_mode: assert property ($rose(watchdog_irq) |-> ctl_q[WDC_CTL_IRQ_EN_BIT])
        else $error("interrupt without interrupt mode");
    a_irq_hold: assert property ($fell(watchdog_irq) |-> $past(clr, 2))
        else $error("interrupt dropped without clear");
    c_rst: cover property ($rose(watchdog_reset));
    c_irq: cover property ($rose(watchdog_irq));
    c_clr: cover property ($fell(watchdog_irq));
endmodule : wdc_top_props
